//--- inc/lrd_pkg.sv
// Package of register map, field positions and fixed legacy I/O ranges for the range decoder
package lrd_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [15:0] OFS_ROUTE_EN   = 16'h2774;
  localparam logic [15:0] OFS_WDOG_BASE  = 16'h2778;
  localparam logic [15:0] OFS_PWR_BL     = 16'h27AC;
  localparam logic [15:0] OFS_PWR_CTL    = 16'h27B0;
  localparam logic [15:0] OFS_ACPI_BASE  = 16'h27B4;
  localparam logic [15:0] OFS_ACPI_TGT   = 16'h27B8;
  // Own registers: range selects and the global lock
  localparam logic [15:0] OFS_RANGE_SEL  = 16'h2770;
  localparam logic [15:0] OFS_LOCK       = 16'h27BC;

  // Writable masks per register, reserved bits read zero
  localparam logic [31:0] MSK_ROUTE_EN   = 32'h0000_030F;
  localparam logic [31:0] MSK_WDOG_BASE  = 32'h0000_FFE2;
  localparam logic [31:0] MSK_PWR_BL     = 32'hFFFF_FFFF;
  localparam logic [31:0] MSK_PWR_CTL    = 32'hFFFF_FFFF;
  localparam logic [31:0] MSK_ACPI_BASE  = 32'h00FC_FFFD;
  localparam logic [31:0] MSK_ACPI_TGT   = 32'hFFFF_FFFF;
  localparam logic [31:0] MSK_RANGE_SEL  = 32'h0000_1377;
  localparam logic [31:0] MSK_LOCK       = 32'h0000_0001;
  localparam logic [31:0] RST_VALUE      = 32'h0000_0000;

  // Route enable bits
  localparam int BIT_HGAME   = 9;
  localparam int BIT_LGAME   = 8;
  localparam int BIT_FLOPPY  = 3;
  localparam int BIT_PAR     = 2;
  localparam int BIT_SER_B   = 1;
  localparam int BIT_SER_A   = 0;
  // Range select fields
  localparam int BIT_FLOPPY_SEL = 12;
  localparam int LSB_PAR_SEL    = 8;
  localparam int LSB_SERB_SEL   = 4;
  localparam int LSB_SERA_SEL   = 0;
  // Watchdog window
  localparam int BIT_WDOG_EN    = 1;
  localparam int LSB_WDOG_BASE  = 5;
  localparam int MSB_WDOG_BASE  = 15;
  // Power range control
  localparam int BIT_PWR_EN     = 31;
  localparam logic [15:0] PWR_LIMIT_LOW = 16'hFFFF;
  localparam logic [15:0] PWR_BASE_LOW  = 16'h0000;
  // ACPI block
  localparam int BIT_ACPI_EN    = 0;
  localparam int LSB_ACPI_MASK  = 18;
  localparam int LSB_ACPI_ADDR  = 2;
  localparam int MSB_ACPI_ADDR  = 15;

  // Fixed ranges
  localparam logic [15:0] HGAME_LO = 16'h0208;
  localparam logic [15:0] HGAME_HI = 16'h020F;
  localparam logic [15:0] LGAME_LO = 16'h0200;
  localparam logic [15:0] LGAME_HI = 16'h0207;

  // Serial port 8-byte block starts, indexed by the 3-bit select
  localparam logic [15:0] SER_BASE [8] = '{16'h03F8, 16'h02F8, 16'h0220, 16'h0228,
                                           16'h0238, 16'h02E8, 16'h0338, 16'h03E8};
  // Parallel ranges: low block, high alias block, last offset within block
  localparam logic [15:0] PAR_BASE [3] = '{16'h0378, 16'h0278, 16'h038C};
  localparam logic [15:0] PAR_ALIAS    = 16'h0400;
  localparam logic [2:0]  PAR_LAST [3] = '{3'h7, 3'h7, 3'h6};
  localparam logic [1:0]  PAR_RSVD     = 2'h3;
  // Floppy primary and secondary block starts; offset 6 is excluded
  localparam logic [15:0] FLP_BASE [2] = '{16'h03F0, 16'h0370};
  localparam logic [2:0]  FLP_HOLE     = 3'h6;

  // Route destination encoding
  typedef enum logic [1:0] {LRD_DEF, LRD_ESPI, LRD_DEST} lrd_route_t;

endpackage

//--- src/lrd_legacy_match.sv
// Fixed legacy I/O range match for gameport, serial, parallel and floppy ports
`timescale 1ns/1ps
module lrd_legacy_match (
  input  wire logic [15:0] io_addr_i,     // I/O address of the cycle
  input  wire logic [31:0] route_en_i,    // Route enable register
  input  wire logic [31:0] range_sel_i,   // Range select register
  output logic             hit_o          // Cycle belongs to an enabled legacy range
);

  logic       hg_hit;     // High gameport hit
  logic       lg_hit;     // Low gameport hit
  logic       sa_hit;     // Serial A hit
  logic       sb_hit;     // Serial B hit
  logic       pp_hit;     // Parallel hit
  logic       fd_hit;     // Floppy hit
  logic [2:0] sa_sel;     // Serial A select
  logic [2:0] sb_sel;     // Serial B select
  logic [1:0] pp_sel;     // Parallel select
  logic       fd_sel;     // Floppy select
  logic [15:0] pp_lo;     // Parallel low block start

  assign sa_sel = range_sel_i[lrd_pkg::LSB_SERA_SEL +: 3];
  assign sb_sel = range_sel_i[lrd_pkg::LSB_SERB_SEL +: 3];
  assign pp_sel = range_sel_i[lrd_pkg::LSB_PAR_SEL +: 2];
  assign fd_sel = range_sel_i[lrd_pkg::BIT_FLOPPY_SEL];

  // Gameport windows are fixed
  assign hg_hit = route_en_i[lrd_pkg::BIT_HGAME] && io_addr_i >= lrd_pkg::HGAME_LO
                  && io_addr_i <= lrd_pkg::HGAME_HI;
  assign lg_hit = route_en_i[lrd_pkg::BIT_LGAME] && io_addr_i >= lrd_pkg::LGAME_LO
                  && io_addr_i <= lrd_pkg::LGAME_HI;

  // Serial ports each match an 8-byte block, independently
  assign sa_hit = route_en_i[lrd_pkg::BIT_SER_A]
                  && io_addr_i[15:3] == lrd_pkg::SER_BASE[sa_sel][15:3];
  assign sb_hit = route_en_i[lrd_pkg::BIT_SER_B]
                  && io_addr_i[15:3] == lrd_pkg::SER_BASE[sb_sel][15:3];

  // Parallel port: primary block plus alias 400h above; reserved code claims nothing
  always_comb begin
    pp_hit = 1'b0;
    pp_lo  = 16'h0000;
    if (route_en_i[lrd_pkg::BIT_PAR] && pp_sel != lrd_pkg::PAR_RSVD) begin
      pp_lo = lrd_pkg::PAR_BASE[pp_sel];
      // Both blocks share the offset bits; compare with the block start and with block start plus 400h
      if ((io_addr_i[15:3] == pp_lo[15:3]
           || io_addr_i[15:3] == 13'(16'(pp_lo + lrd_pkg::PAR_ALIAS) >> 3))
          && io_addr_i[2:0] >= pp_lo[2:0]
          && io_addr_i[2:0] <= lrd_pkg::PAR_LAST[pp_sel]) begin
        pp_hit = 1'b1;
      end
    end
  end

  // Floppy: six ports plus one, skipping the offset 6 port
  assign fd_hit = route_en_i[lrd_pkg::BIT_FLOPPY]
                  && io_addr_i[15:3] == lrd_pkg::FLP_BASE[fd_sel][15:3]
                  && io_addr_i[2:0] != lrd_pkg::FLP_HOLE;

  assign hit_o = hg_hit | lg_hit | sa_hit | sb_hit | pp_hit | fd_hit;

endmodule

//--- src/lrd_top.sv
// Legacy I/O range decoder: Wishbone register file and cycle routing
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module lrd_top (
  input  wire logic        mclk_i,          // System clock, 200 MHz
  input  wire logic        rst_i,           // Synchronous reset, active high
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,        // Bus cycle
  input  wire logic        wb_stb_i,        // Strobe
  input  wire logic        wb_we_i,         // Write enable
  input  wire logic [15:0] wb_adr_i,        // Byte address
  input  wire logic [3:0]  wb_sel_i,        // Byte lane selects
  input  wire logic [31:0] wb_dat_i,        // Write data
  output logic      [31:0] wb_dat_o,        // Read data
  output logic             wb_ack_o,        // Acknowledge
  // Upstream host cycle
  input  wire logic        cyc_valid_i,     // Cycle present
  input  wire logic        cyc_is_mem_i,    // 1 memory cycle, 0 I/O cycle
  input  wire logic        cyc_write_i,     // Write direction
  input  wire logic [31:0] cyc_addr_i,      // Address
  input  wire logic [31:0] cyc_data_i,      // Write data
  output logic             cyc_ready_o,     // Cycle accepted
  // Routed cycle
  output logic             out_valid_o,     // Routed cycle present
  output logic [1:0]       out_route_o,     // Destination kind
  output logic [31:0]      out_dest_id_o,   // Destination ID for programmed routes
  output logic             out_write_o,     // Write direction
  output logic [31:0]      out_addr_o,      // Address, unmodified
  output logic [31:0]      out_data_o,      // Data, unmodified
  input  wire logic        out_ready_i      // Downstream accepts
);

  // Registers
  logic [31:0] route_en_q;     // Legacy route enables
  logic [31:0] wdog_base_q;    // Watchdog window base and enable
  logic [31:0] pwr_bl_q;       // Power range base and limit
  logic [31:0] pwr_ctl_q;      // Power range enable and target
  logic [31:0] acpi_base_q;    // ACPI block address, mask, enable
  logic [31:0] acpi_tgt_q;     // ACPI target ID
  logic [31:0] range_sel_q;    // Legacy range selects
  logic        lock_q;         // Global configuration lock

  // Bus decode
  logic        wb_req;         // Request present this cycle
  logic        wb_wr;          // Write taken at acknowledge
  logic [31:0] lane_mask;      // Byte lanes as a bit mask
  logic [31:0] rd_d;           // Read mux

  // Output stage
  logic        out_valid_q;    // Held cycle valid
  logic [1:0]  out_route_q;    // Held route
  logic [31:0] out_dest_q;     // Held destination
  logic        out_write_q;    // Held direction
  logic [31:0] out_addr_q;     // Held address
  logic [31:0] out_data_q;     // Held data

  // Decode results
  logic        legacy_hit;     // Legacy fixed range hit
  logic        wdog_hit;       // Watchdog window hit
  logic        pwr_hit;        // Power memory range hit
  logic        acpi_hit;       // ACPI block hit
  logic [31:0] pwr_limit;      // Full limit address
  logic [31:0] pwr_base;       // Full base address
  logic [13:0] acpi_care;      // Address bits compared for ACPI
  lrd_pkg::lrd_route_t route_d; // Route decided for the incoming cycle
  logic [31:0] dest_d;         // Destination decided

  // Single-wait-state answer: ack one cycle after the request, dropped after
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // Expand byte selects into a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  // Merge helper: keep writable, selected bits from the bus
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] wmask,
                                        input logic [31:0] lmask);
    logic [31:0] m;
    m = wmask & lmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Acknowledge; unmapped addresses are acked too and read zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (wb_adr_i)
      lrd_pkg::OFS_ROUTE_EN:  rd_d = route_en_q;
      lrd_pkg::OFS_WDOG_BASE: rd_d = wdog_base_q;
      lrd_pkg::OFS_PWR_BL:    rd_d = pwr_bl_q;
      lrd_pkg::OFS_PWR_CTL:   rd_d = pwr_ctl_q;
      lrd_pkg::OFS_ACPI_BASE: rd_d = acpi_base_q;
      lrd_pkg::OFS_ACPI_TGT:  rd_d = acpi_tgt_q;
      lrd_pkg::OFS_RANGE_SEL: rd_d = range_sel_q;
      lrd_pkg::OFS_LOCK:      rd_d = {31'h0000_0000, lock_q};
      default:                rd_d = lrd_pkg::RST_VALUE;   // Unmapped reads zero
    endcase
  end

  // Read data registered alongside ack
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_dat_o <= lrd_pkg::RST_VALUE;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end

  // Decode registers; all writes dropped while locked, no error reported
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      route_en_q  <= lrd_pkg::RST_VALUE;
      wdog_base_q <= lrd_pkg::RST_VALUE;
      pwr_bl_q    <= lrd_pkg::RST_VALUE;
      pwr_ctl_q   <= lrd_pkg::RST_VALUE;
      acpi_base_q <= lrd_pkg::RST_VALUE;
      acpi_tgt_q  <= lrd_pkg::RST_VALUE;
      range_sel_q <= lrd_pkg::RST_VALUE;
    end else if (wb_wr && !lock_q) begin
      unique case (wb_adr_i)
        lrd_pkg::OFS_ROUTE_EN:
          route_en_q  <= merge(route_en_q, wb_dat_i, lrd_pkg::MSK_ROUTE_EN, lane_mask);
        lrd_pkg::OFS_WDOG_BASE:
          wdog_base_q <= merge(wdog_base_q, wb_dat_i, lrd_pkg::MSK_WDOG_BASE, lane_mask);
        lrd_pkg::OFS_PWR_BL:
          pwr_bl_q    <= merge(pwr_bl_q, wb_dat_i, lrd_pkg::MSK_PWR_BL, lane_mask);
        lrd_pkg::OFS_PWR_CTL:
          pwr_ctl_q   <= merge(pwr_ctl_q, wb_dat_i, lrd_pkg::MSK_PWR_CTL, lane_mask);
        lrd_pkg::OFS_ACPI_BASE:
          acpi_base_q <= merge(acpi_base_q, wb_dat_i, lrd_pkg::MSK_ACPI_BASE, lane_mask);
        lrd_pkg::OFS_ACPI_TGT:
          acpi_tgt_q  <= merge(acpi_tgt_q, wb_dat_i, lrd_pkg::MSK_ACPI_TGT, lane_mask);
        lrd_pkg::OFS_RANGE_SEL:
          range_sel_q <= merge(range_sel_q, wb_dat_i, lrd_pkg::MSK_RANGE_SEL, lane_mask);
        default: ;                                         // Other addresses store nothing
      endcase
    end
  end

  // Lock is set-once; only reset clears it, so a locked map cannot be reopened
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (wb_wr && wb_adr_i == lrd_pkg::OFS_LOCK && wb_sel_i[0]
                 && wb_dat_i[0]) begin
      lock_q <= 1'b1;
    end
  end

  // Fixed legacy ranges live in the helper module
  lrd_legacy_match u_legacy (
    .io_addr_i   (cyc_addr_i[15:0]),
    .route_en_i  (route_en_q),
    .range_sel_i (range_sel_q),
    .hit_o       (legacy_hit)
  );

  // Watchdog window: compare address bits 15:5 against the base
  assign wdog_hit = wdog_base_q[lrd_pkg::BIT_WDOG_EN]
                    && cyc_addr_i[lrd_pkg::MSB_WDOG_BASE:lrd_pkg::LSB_WDOG_BASE]
                       == wdog_base_q[lrd_pkg::MSB_WDOG_BASE:lrd_pkg::LSB_WDOG_BASE];

  // Power memory range limits, both ends inclusive
  assign pwr_limit = {pwr_bl_q[31:16], lrd_pkg::PWR_LIMIT_LOW};
  assign pwr_base  = {pwr_bl_q[15:0], lrd_pkg::PWR_BASE_LOW};
  assign pwr_hit   = pwr_ctl_q[lrd_pkg::BIT_PWR_EN]
                     && cyc_addr_i >= pwr_base && cyc_addr_i <= pwr_limit;

  // ACPI block: mask clears compare on bits 7:2; bits 1:0 never compared
  assign acpi_care = {8'hFF, ~acpi_base_q[lrd_pkg::LSB_ACPI_MASK +: 6]};
  assign acpi_hit  = acpi_base_q[lrd_pkg::BIT_ACPI_EN]
                     && ((cyc_addr_i[lrd_pkg::MSB_ACPI_ADDR:lrd_pkg::LSB_ACPI_ADDR]
                         ^ acpi_base_q[lrd_pkg::MSB_ACPI_ADDR:lrd_pkg::LSB_ACPI_ADDR])
                         & acpi_care) == 14'h0000;

  // Route priority: ACPI, watchdog, legacy for I/O; power range for memory
  always_comb begin
    route_d = lrd_pkg::LRD_DEF;
    dest_d  = lrd_pkg::RST_VALUE;
    if (cyc_is_mem_i) begin
      if (pwr_hit) begin
        route_d = lrd_pkg::LRD_DEST;
        dest_d  = {1'b0, pwr_ctl_q[30:0]};
      end
    end else if (acpi_hit) begin
      route_d = lrd_pkg::LRD_DEST;
      dest_d  = acpi_tgt_q;
    end else if (wdog_hit || legacy_hit) begin
      route_d = lrd_pkg::LRD_ESPI;
    end
  end

  // Stage accepts a new cycle when empty or draining this edge
  assign cyc_ready_o = !out_valid_q || out_ready_i;

  // Output stage: address and data pass through untouched
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_valid_q <= 1'b0;
      out_route_q <= lrd_pkg::LRD_DEF;
      out_dest_q  <= lrd_pkg::RST_VALUE;
      out_write_q <= 1'b0;
      out_addr_q  <= lrd_pkg::RST_VALUE;
      out_data_q  <= lrd_pkg::RST_VALUE;
    end else if (cyc_ready_o) begin
      out_valid_q <= cyc_valid_i;
      if (cyc_valid_i) begin
        out_route_q <= route_d;
        out_dest_q  <= dest_d;
        out_write_q <= cyc_write_i;
        out_addr_q  <= cyc_addr_i;
        out_data_q  <= cyc_data_i;
      end
    end
  end

  assign out_valid_o   = out_valid_q;
  assign out_route_o   = out_route_q;
  assign out_dest_id_o = out_dest_q;
  assign out_write_o   = out_write_q;
  assign out_addr_o    = out_addr_q;
  assign out_data_o    = out_data_q;

endmodule

//--- test/lrd_top_sva.sv
// Port-level assertions for the legacy I/O range decoder
`timescale 1ns/1ps
module lrd_top_sva (
  input wire logic        mclk_i,        // Clock
  input wire logic        rst_i,         // Synchronous reset
  input wire logic        wb_cyc_i,      // Bus cycle
  input wire logic        wb_stb_i,      // Strobe
  input wire logic        wb_we_i,       // Write enable
  input wire logic [15:0] wb_adr_i,      // Byte address
  input wire logic [31:0] wb_dat_o,      // Read data
  input wire logic        wb_ack_o,      // Acknowledge
  input wire logic        cyc_valid_i,   // Host cycle present
  input wire logic        cyc_is_mem_i,  // Memory cycle
  input wire logic        cyc_write_i,   // Host direction
  input wire logic [31:0] cyc_addr_i,    // Host address
  input wire logic [31:0] cyc_data_i,    // Host data
  input wire logic        cyc_ready_o,   // Host cycle accepted
  input wire logic        out_valid_o,   // Routed cycle present
  input wire logic [1:0]  out_route_o,   // Destination kind
  input wire logic [31:0] out_dest_id_o, // Destination ID
  input wire logic        out_write_o,   // Routed direction
  input wire logic [31:0] out_addr_o,    // Routed address
  input wire logic [31:0] out_data_o,    // Routed data
  input wire logic        out_ready_i    // Downstream accepts
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge late or too long");
  rsvd_read_zero_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == lrd_pkg::OFS_ROUTE_EN
    |=> (wb_dat_o & ~32'h0000_030F) == 32'h0)
    else $error("reserved enable bits read nonzero");
  reset_quiet_a: assert property (
    $fell(rst_i) |-> !out_valid_o && !wb_ack_o && cyc_ready_o)
    else $error("outputs busy right after reset");
  ready_flow_a: assert property (
    cyc_ready_o == (!out_valid_o || out_ready_i))
    else $error("host ready does not follow downstream");
  hold_stall_a: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_route_o)
    && $stable(out_dest_id_o) && $stable(out_addr_o))
    else $error("routed cycle changed while stalled");
  pass_thru_a: assert property (
    cyc_valid_i && cyc_ready_o |=> out_valid_o && out_addr_o == $past(cyc_addr_i)
    && out_data_o == $past(cyc_data_i) && out_write_o == $past(cyc_write_i))
    else $error("routed cycle altered or missing");
  mem_not_espi_a: assert property (
    cyc_valid_i && cyc_ready_o && cyc_is_mem_i |=> out_route_o != lrd_pkg::LRD_ESPI)
    else $error("memory cycle sent to eSPI");
  dest_idle_a: assert property (
    out_valid_o && out_route_o != lrd_pkg::LRD_DEST |-> out_dest_id_o == 32'h0)
    else $error("destination ID without programmed route");
  drain_a: assert property (
    out_valid_o && out_ready_i && !cyc_valid_i |=> !out_valid_o)
    else $error("routed cycle not retired");
endmodule

bind lrd_top lrd_top_sva u_sva (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .cyc_valid_i, .cyc_is_mem_i, .cyc_write_i, .cyc_addr_i, .cyc_data_i,
  .cyc_ready_o, .out_valid_o, .out_route_o, .out_dest_id_o, .out_write_o, .out_addr_o,
  .out_data_o, .out_ready_i);

//--- test/lrd_sink.sv
// Downstream port model that accepts routed cycles, promptly or after a stall
`timescale 1ns/1ps
module lrd_sink (
  input  wire logic mclk_i,      // Clock
  input  wire logic rst_i,       // Synchronous reset
  input  wire logic slow_i,      // Stall each cycle for three clocks
  input  wire logic out_valid_i, // Routed cycle present
  output logic      out_ready_o  // Accept
);
  logic [1:0] wait_q; // Stall cycles spent on the current routed cycle

  // Count stalled cycles; a fresh count per offered cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i || !out_valid_i || out_ready_o) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // Slow mode forces the decoder to hold its outputs and back-pressure the host
  assign out_ready_o = !slow_i || (wait_q == 2'h3);
endmodule

//--- test/lrd_top_tb.sv
// Testbench for the legacy I/O range decoder
`timescale 1ns/1ps
module lrd_top_tb;
  localparam logic [15:0] SER [8] = '{16'h03F8, 16'h02F8, 16'h0220, 16'h0228,
                                     16'h0238, 16'h02E8, 16'h0338, 16'h03E8};
  localparam logic [15:0] PB [3] = '{16'h0378, 16'h0278, 16'h038C};
  localparam logic [15:0] REGS [8] = '{16'h2770, 16'h2774, 16'h2778, 16'h27AC,
                                      16'h27B0, 16'h27B4, 16'h27B8, 16'h27BC};
  localparam logic [1:0]  DEF = lrd_pkg::LRD_DEF;  // Unclaimed
  localparam logic [1:0]  ESP = lrd_pkg::LRD_ESPI; // To eSPI
  localparam logic [1:0]  DST = lrd_pkg::LRD_DEST; // To programmed ID
  logic        mclk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
  logic        cyc_valid_i, cyc_is_mem_i, cyc_write_i, cyc_ready_o;
  logic        out_valid_o, out_write_o, out_ready_i;
  logic [1:0]  out_route_o;
  logic [3:0]  wb_sel_i;
  logic [15:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, cyc_addr_i, cyc_data_i, out_dest_id_o, out_addr_o, out_data_o;
  logic [31:0] rd;         // Last read data
  int          n_fail, checks, cyc_cnt;

  lrd_top u_dut (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cyc_valid_i, .cyc_is_mem_i, .cyc_write_i, .cyc_addr_i,
    .cyc_data_i, .cyc_ready_o, .out_valid_o, .out_route_o, .out_dest_id_o, .out_write_o,
    .out_addr_o, .out_data_o, .out_ready_i);
  lrd_sink u_sink (.mclk_i, .rst_i, .slow_i(slow), .out_valid_i(out_valid_o),
    .out_ready_o(out_ready_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // One host cycle; data and direction derive from the address so they vary
  task automatic io(input logic mem, input logic [31:0] a, input logic [1:0] r,
                    input logic [31:0] d);
    cyc_valid_i  <= 1'b1;
    cyc_is_mem_i <= mem;
    cyc_addr_i   <= a;
    cyc_data_i   <= ~a;
    cyc_write_i  <= a[0];
    do @(posedge mclk_i); while (cyc_ready_o !== 1'b1);
    cyc_valid_i <= 1'b0;
    #1;
    chk(out_valid_o, 32'h1, "valid");
    chk(out_route_o, r, "route");
    chk(out_dest_id_o, d, "dest id");
    chk({31'h0, out_write_o}, {31'h0, a[0]}, "pass dir");
    chk(out_addr_o, a, "pass addr");
    chk(out_data_o, ~a, "pass data");
    @(posedge mclk_i);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Clock, 5 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Hang guard, well above the expected run of a few hundred cycles
  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    {rst_i, wb_sel_i} = 5'h1F;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {cyc_valid_i, cyc_is_mem_i, cyc_write_i, cyc_addr_i, cyc_data_i, slow} = '0;
    {n_fail, checks, cyc_cnt} = '0;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    foreach (REGS[i]) begin
      wb(1'b0, REGS[i], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    wb(1'b1, 16'h2800, 32'hFFFF_FFFF);
    wb(1'b0, 16'h2800, 32'h0);
    chk(rd, 32'h0, "unmapped");
    io(1'b0, 32'h03F8, DEF, 32'h0);
    wb(1'b1, REGS[1], 32'h200);
    io(1'b0, 32'h020F, ESP, 32'h0);
    io(1'b0, 32'h0207, DEF, 32'h0);
    wb(1'b1, REGS[1], 32'h100);
    io(1'b0, 32'h0200, ESP, 32'h0);
    io(1'b0, 32'h0208, DEF, 32'h0);
    $display("test gameport done");
    slow <= 1'b1;
    // Serial B and A pick different codes, each enabled alone
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, REGS[0], {25'h0, c[2:0], 1'b0, ~c[2:0]});
      wb(1'b1, REGS[1], 32'h2);
      io(1'b0, {16'h0, SER[c]} + 32'h7, ESP, 32'h0);
      io(1'b0, {16'h0, SER[c]} + 32'h8, DEF, 32'h0);
      io(1'b0, {16'h0, SER[7-c]}, DEF, 32'h0);
      wb(1'b1, REGS[1], 32'h1);
      io(1'b0, {16'h0, SER[7-c]}, ESP, 32'h0);
      io(1'b0, {16'h0, SER[c]}, DEF, 32'h0);
    end
    slow <= 1'b0;
    // Parallel codes, alias block at plus 400h, reserved code claims nothing
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, REGS[0], {22'h0, c[1:0], 8'h0});
      wb(1'b1, REGS[1], 32'h4);
      if (c < 3) begin
        io(1'b0, {16'h0, PB[c]}, ESP, 32'h0);
        io(1'b0, {16'h0, PB[c]} + ((c == 2) ? 32'h402 : 32'h407), ESP, 32'h0);
        io(1'b0, {16'h0, PB[c]} + ((c == 2) ? 32'h3 : 32'h8), DEF, 32'h0);
      end else begin
        io(1'b0, 32'h0378, DEF, 32'h0);
      end
    end
    wb(1'b1, REGS[0], 32'h0);
    wb(1'b1, REGS[1], 32'h8);
    io(1'b0, 32'h03F7, ESP, 32'h0);
    io(1'b0, 32'h03F6, DEF, 32'h0);
    wb(1'b1, REGS[0], 32'h1000);
    io(1'b0, 32'h0370, ESP, 32'h0);
    io(1'b0, 32'h03F0, DEF, 32'h0);
    wb(1'b1, REGS[1], 32'hFFFF_FFFF);
    wb(1'b0, REGS[1], 32'h0);
    chk(rd, 32'h0000_030F, "enable reg");
    $display("test legacy ranges done");
    wb(1'b1, REGS[2], 32'hFFFF_FFFF);
    wb(1'b0, REGS[2], 32'h0);
    chk(rd, 32'h0000_FFE2, "window reg");
    io(1'b0, 32'hFFFF, ESP, 32'h0);
    io(1'b0, 32'hFFDF, DEF, 32'h0);
    wb(1'b1, REGS[2], 32'h0000_ABE0);
    io(1'b0, 32'hABE0, DEF, 32'h0);
    wb(1'b1, REGS[2], 32'h0000_ABE2);
    io(1'b0, 32'hABE0, ESP, 32'h0);
    io(1'b0, 32'hAC00, DEF, 32'h0);
    $display("test window done");
    wb(1'b1, REGS[3], 32'h1234_1230);
    wb(1'b1, REGS[4], 32'hFFFF_FFFF);
    io(1'b1, 32'h1230_0000, DST, 32'h7FFF_FFFF);
    io(1'b1, 32'h1234_FFFF, DST, 32'h7FFF_FFFF);
    io(1'b1, 32'h1235_0000, DEF, 32'h0);
    io(1'b1, 32'h122F_FFFF, DEF, 32'h0);
    io(1'b1, 32'h0000_03F8, DEF, 32'h0);
    wb(1'b1, REGS[4], 32'h7FFF_FFFF);
    io(1'b1, 32'h1231_0000, DEF, 32'h0);
    $display("test power range done");
    wb(1'b1, REGS[5], 32'hFFFF_FFFF);
    wb(1'b0, REGS[5], 32'h0);
    chk(rd, 32'h00FC_FFFD, "block reg");
    wb(1'b1, REGS[6], 32'hCAFE_0001);
    wb(1'b1, REGS[5], 32'h000C_ABE1);
    io(1'b0, 32'hABEC, DST, 32'hCAFE_0001);
    io(1'b0, 32'hABE3, DST, 32'hCAFE_0001);
    io(1'b0, 32'hABF0, ESP, 32'h0);
    wb(1'b1, REGS[5], 32'h000C_ABE0);
    io(1'b0, 32'hABE4, ESP, 32'h0);
    $display("test block done");
    wb(1'b1, REGS[7], 32'h1);
    wb(1'b1, REGS[1], 32'h0);
    wb(1'b0, REGS[1], 32'h0);
    chk(rd, 32'h0000_030F, "locked reg");
    wb(1'b1, REGS[2], 32'h0);
    io(1'b0, 32'hABE0, ESP, 32'h0);
    wb(1'b1, REGS[7], 32'h0);
    wb(1'b0, REGS[7], 32'h0);
    chk(rd, 32'h1, "lock reg");
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    wb(1'b0, REGS[1], 32'h0);
    chk(rd, 32'h0, "after reset");
    $display("test lock done");
    finish_test();
  end
endmodule
